// ### verilog/ddc_regs.vh
// constants for the dram command decoder
`ifndef DDC_REGS_VH
`define DDC_REGS_VH
`define DDC_BANKS 8
`define DDC_BANK_W 3
`define DDC_ADDR_W 13
`define DDC_AP_POS 10
`define DDC_BC_POS 12
// command codes on the decoded command output
`define DDC_CMD_DESELECT 4'h0
`define DDC_CMD_NOP 4'h1
`define DDC_CMD_ACTIVATE 4'h2
`define DDC_CMD_PRECHARGE 4'h3
`define DDC_CMD_PRECHARGE_ALL 4'h4
`define DDC_CMD_WRITE 4'h5
`define DDC_CMD_READ 4'h6
`define DDC_CMD_MODE_LOAD 4'h7
`define DDC_CMD_REFRESH 4'h8
`define DDC_CMD_SELF_REF_ENTRY 4'h9
`define DDC_CMD_SELF_REF_EXIT 4'ha
`define DDC_CMD_PD_ENTRY 4'hb
`define DDC_CMD_PD_EXIT 4'hc
`define DDC_CMD_CAL_LONG 4'hd
`define DDC_CMD_CAL_SHORT 4'he
`define DDC_CMD_ILLEGAL 4'hf
// power states
`define DDC_PWR_ON 2'h0
`define DDC_PWR_DOWN 2'h1
`define DDC_PWR_SELF_REF 2'h2
`endif

// ### verilog/ddc_decoder.v
// command decoder and bank state tracker of an eight bank ddr dram
`timescale 1ns/1ps
`include "ddc_regs.vh"

// Notes on behaviour
// - chip select high starts no command
// - nop starts nothing, keeps ongoing work
// - activate opens idle bank with row
// - row stays open until bank precharged
// - precharge closes one bank or all
// - other bank access allowed during auto precharge
// - precharge of idle bank accepted, restarts
// - write to active bank, optional auto precharge
// - read to active bank, optional auto precharge
// - burst chop bit picks four or eight
// - mode load with all banks idle
// - refresh, self refresh entry and exit
// - power down entry and exit by clock enable
// - decode uses previous and present clock enable
// - data masks pass or block write bytes
// - calibration long or short by bit
// - command inputs sampled on link clock rise
// - on the fly chop only when enabled
module ddc_decoder #(
  parameter BANKS = `DDC_BANKS,
  parameter BANK_W = `DDC_BANK_W,
  parameter ADDR_W = `DDC_ADDR_W
) (
  // system
  input wire clk,
  input wire rst,
  // link from the controller
  input wire link_clk,
  input wire clk_en,
  input wire chip_select_n,
  input wire row_strobe_n,
  input wire col_strobe_n,
  input wire write_strobe_n,
  input wire [BANK_W-1:0] bank_select_bits,
  input wire [ADDR_W-1:0] addr,
  input wire lower_byte_mask,
  input wire upper_byte_mask,
  // configuration
  input wire otf_chop_enable,
  input wire fixed_chop,
  // decoded command
  output reg cmd_valid,
  output reg [3:0] cmd_code,
  output reg [BANK_W-1:0] cmd_bank,
  output reg [ADDR_W-1:0] cmd_addr,
  output reg cmd_auto_precharge,
  output reg chopped_burst_of_four,
  output reg burst_of_eight,
  output reg cmd_refused,
  // state
  output reg [BANKS-1:0] bank_open,
  output reg [BANKS*ADDR_W-1:0] open_rows,
  output reg [1:0] power_state,
  // write data masking
  output reg lower_pass,
  output reg upper_pass
);

  localparam IN_W = 8 + BANK_W + ADDR_W;

  // two stage synchronisers for all link inputs
  reg [IN_W-1:0] in_s1;
  reg [IN_W-1:0] in_s2;
  reg lclk_d;
  reg cke_prev;
  wire [IN_W-1:0] in_raw;
  assign in_raw = {link_clk, clk_en, chip_select_n, row_strobe_n,
                   col_strobe_n, write_strobe_n, lower_byte_mask,
                   upper_byte_mask, bank_select_bits, addr};

  always @(posedge clk) begin
    if (rst) begin
      in_s1 <= {IN_W{1'b0}};
      in_s2 <= {IN_W{1'b0}};
      lclk_d <= 1'b0;
    end else begin
      in_s1 <= in_raw;
      in_s2 <= in_s1;
      lclk_d <= in_s2[IN_W-1];
    end
  end

  wire s_lclk;
  wire s_cke;
  wire s_cs_n;
  wire s_ras_n;
  wire s_cas_n;
  wire s_we_n;
  wire s_ldm;
  wire s_udm;
  wire [BANK_W-1:0] s_bank;
  wire [ADDR_W-1:0] s_addr;
  assign s_lclk = in_s2[IN_W-1];
  assign s_cke = in_s2[IN_W-2];
  assign s_cs_n = in_s2[IN_W-3];
  assign s_ras_n = in_s2[IN_W-4];
  assign s_cas_n = in_s2[IN_W-5];
  assign s_we_n = in_s2[IN_W-6];
  assign s_ldm = in_s2[IN_W-7];
  assign s_udm = in_s2[IN_W-8];
  assign s_bank = in_s2[BANK_W+ADDR_W-1:ADDR_W];
  assign s_addr = in_s2[ADDR_W-1:0];

  // the slow link clock is oversampled; commands are taken on its rise
  wire sample;
  assign sample = s_lclk & ~lclk_d;

  wire ap;
  wire bc;
  wire sel_bank_open;
  wire all_idle;
  wire idle_or_nop;
  assign ap = s_addr[`DDC_AP_POS];
  assign bc = s_addr[`DDC_BC_POS];
  assign sel_bank_open = bank_open[s_bank];
  assign all_idle = ~|bank_open;
  assign idle_or_nop = s_cs_n | (s_ras_n & s_cas_n & s_we_n);

  // combinational command decode
  reg [3:0] next_code;
  reg next_ok;
  always @* begin
    next_code = `DDC_CMD_ILLEGAL;
    next_ok = 1'b1;
    if (cke_prev & ~s_cke) begin
      if (~s_cs_n & ~s_ras_n & ~s_cas_n & s_we_n) begin
        next_code = `DDC_CMD_SELF_REF_ENTRY;
        next_ok = all_idle;
      end else if (idle_or_nop) begin
        next_code = `DDC_CMD_PD_ENTRY;
        next_ok = 1'b1;
      end else begin
        next_ok = 1'b0;
      end
    end else if (~cke_prev & s_cke) begin
      if (idle_or_nop) begin
        if (power_state == `DDC_PWR_SELF_REF) begin
          next_code = `DDC_CMD_SELF_REF_EXIT;
        end else begin
          next_code = `DDC_CMD_PD_EXIT;
        end
      end else begin
        next_ok = 1'b0;
      end
    end else if (~cke_prev) begin
      next_code = `DDC_CMD_DESELECT;
    end else if (s_cs_n) begin
      next_code = `DDC_CMD_DESELECT;
    end else begin
      case ({s_ras_n, s_cas_n, s_we_n})
        3'b111: next_code = `DDC_CMD_NOP;
        3'b011: begin
          next_code = `DDC_CMD_ACTIVATE;
          next_ok = ~sel_bank_open;
        end
        3'b010: begin
          // idle or precharging banks accept it too
          next_code = ap ? `DDC_CMD_PRECHARGE_ALL :
                           `DDC_CMD_PRECHARGE;
        end
        3'b100: begin
          next_code = `DDC_CMD_WRITE;
          next_ok = sel_bank_open;
        end
        3'b101: begin
          next_code = `DDC_CMD_READ;
          next_ok = sel_bank_open;
        end
        3'b000: begin
          next_code = `DDC_CMD_MODE_LOAD;
          next_ok = all_idle;
        end
        3'b001: begin
          next_code = `DDC_CMD_REFRESH;
          next_ok = all_idle;
        end
        3'b110: begin
          next_code = ap ? `DDC_CMD_CAL_LONG :
                           `DDC_CMD_CAL_SHORT;
          next_ok = all_idle;
        end
        default: next_ok = 1'b0;
      endcase
    end
  end

  wire is_rw;
  wire take;
  assign is_rw = (next_code == `DDC_CMD_WRITE) |
                 (next_code == `DDC_CMD_READ);
  assign take = sample & next_ok;

  // burst length: bit only honoured when on the fly is enabled
  wire next_chop;
  assign next_chop = otf_chop_enable ? ~bc : fixed_chop;

  always @(posedge clk) begin
    if (rst) begin
      cke_prev <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= `DDC_CMD_DESELECT;
      cmd_bank <= {BANK_W{1'b0}};
      cmd_addr <= {ADDR_W{1'b0}};
      cmd_auto_precharge <= 1'b0;
      chopped_burst_of_four <= 1'b0;
      burst_of_eight <= 1'b0;
      cmd_refused <= 1'b0;
      power_state <= `DDC_PWR_ON;
      lower_pass <= 1'b0;
      upper_pass <= 1'b0;
    end else begin
      cmd_valid <= take;
      cmd_refused <= sample & ~next_ok;
      if (sample) begin
        cke_prev <= s_cke;
        // masks only meaningful with an open bank and clock enabled
        lower_pass <= cke_prev & ~all_idle & ~s_ldm;
        upper_pass <= cke_prev & ~all_idle & ~s_udm;
      end
      if (take) begin
        cmd_code <= next_code;
        cmd_bank <= s_bank;
        cmd_addr <= s_addr;
        cmd_auto_precharge <= is_rw & ap;
        chopped_burst_of_four <= is_rw & next_chop;
        burst_of_eight <= is_rw & ~next_chop;
        case (next_code)
          `DDC_CMD_SELF_REF_ENTRY: power_state <= `DDC_PWR_SELF_REF;
          `DDC_CMD_PD_ENTRY: power_state <= `DDC_PWR_DOWN;
          `DDC_CMD_SELF_REF_EXIT: power_state <= `DDC_PWR_ON;
          `DDC_CMD_PD_EXIT: power_state <= `DDC_PWR_ON;
          default: power_state <= power_state;
        endcase
      end
    end
  end

  // per bank open state and row
  genvar b;
  generate
    for (b = 0; b < BANKS; b = b + 1) begin : g_bank
      localparam [BANK_W-1:0] IDX = b;
      wire hit;
      assign hit = (s_bank == IDX);
      always @(posedge clk) begin
        if (rst) begin
          bank_open[b] <= 1'b0;
          open_rows[b*ADDR_W +: ADDR_W] <= {ADDR_W{1'b0}};
        end else if (take) begin
          if (next_code == `DDC_CMD_ACTIVATE && hit) begin
            bank_open[b] <= 1'b1;
            open_rows[b*ADDR_W +: ADDR_W] <= s_addr;
          end else if (next_code == `DDC_CMD_PRECHARGE_ALL ||
                       (next_code == `DDC_CMD_PRECHARGE && hit)) begin
            bank_open[b] <= 1'b0;
          end else if (is_rw && ap && hit) begin
            // auto precharge closes only this bank
            bank_open[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // ddc_decoder

// ### verif/ddc_decoder_assertions.sv
// concurrent checks on the command decoder ports
`timescale 1ns/1ps
`include "ddc_regs.vh"
module ddc_chk (
  // system
  input wire clk,
  input wire rst,
  // link
  input wire link_clk,
  // decoded command and bank state
  input wire cmd_valid,
  input wire cmd_refused,
  input wire [3:0] cmd_code,
  input wire [2:0] cmd_bank,
  input wire cmd_auto_precharge,
  input wire chopped_burst_of_four,
  input wire burst_of_eight,
  input wire [7:0] bank_open
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rw = cmd_code == `DDC_CMD_READ || cmd_code == `DDC_CMD_WRITE;
  sequence link_rise; $rose(link_clk); endsequence
  sequence answer; ##[3:5] (cmd_valid || cmd_refused); endsequence
  answer_time_a: assert property (link_rise |-> answer)
    else $error("no answer to link edge");
  act_opens_a: assert property (
    cmd_valid && cmd_code == `DDC_CMD_ACTIVATE |-> bank_open[cmd_bank])
    else $error("activate left bank shut");
  pre_closes_a: assert property (
    cmd_valid && cmd_code == `DDC_CMD_PRECHARGE |-> !bank_open[cmd_bank])
    else $error("precharge left bank open");
  all_close_a: assert property (
    cmd_valid && cmd_code == `DDC_CMD_PRECHARGE_ALL |-> bank_open == 8'h00)
    else $error("banks open after precharge all");
  idle_only_a: assert property (
    cmd_valid && cmd_code inside {`DDC_CMD_MODE_LOAD, `DDC_CMD_REFRESH,
    `DDC_CMD_CAL_LONG, `DDC_CMD_CAL_SHORT} |-> bank_open == 8'h00)
    else $error("idle command with open bank");
  rw_bank_a: assert property (
    cmd_valid && rw |-> bank_open[cmd_bank] != cmd_auto_precharge)
    else $error("access bank state wrong");
  burst_len_a: assert property (
    cmd_valid && rw |-> chopped_burst_of_four != burst_of_eight)
    else $error("burst length not one of two");
  quiet_banks_a: assert property (
    bank_open != $past(bank_open) |-> cmd_valid)
    else $error("bank state moved on its own");
endmodule // ddc_chk
bind ddc_decoder ddc_chk u_chk (.clk(clk), .rst(rst), .link_clk(link_clk),
  .cmd_valid(cmd_valid), .cmd_refused(cmd_refused), .cmd_code(cmd_code),
  .cmd_bank(cmd_bank), .cmd_auto_precharge(cmd_auto_precharge),
  .chopped_burst_of_four(chopped_burst_of_four),
  .burst_of_eight(burst_of_eight), .bank_open(bank_open));

// ### verif/ddc_ctrl_model.sv
// memory controller model driving the command bus
`timescale 1ns/1ps
module ddc_ctrl_model (
  // system
  input wire clk,
  // command bus
  output reg link_clk,
  output reg clk_en,
  output reg [3:0] enc,
  output reg [2:0] bank,
  output reg [12:0] addr
);
  initial begin
    link_clk = 1'b0;
    clk_en = 1'b0;
    enc = 4'hf;
    bank = 3'h0;
    addr = 13'h0;
  end
  // link clock pulses only inside a command, so none repeats
  task send(input [3:0] c, input [2:0] q, input [12:0] d, input k);
    begin
      @(posedge clk);
      enc <= c;
      bank <= q;
      addr <= d;
      clk_en <= k;
      #21.7 link_clk = 1'b1;
      // link clock held high for 24 ns, then dropped before the next command
      #24 link_clk = 1'b0;
      @(posedge clk);
      enc <= 4'hf;
      bank <= ~q;
      addr <= ~d;
    end
  endtask
endmodule // ddc_ctrl_model

// ### verif/test_dram_command_decoder.sv
// self-checking bench for the dram command decoder
`timescale 1ns/1ps
`include "ddc_regs.vh"
module test_dram_command_decoder;
  localparam [3:0] ILL = `DDC_CMD_ILLEGAL;
  localparam [3:0] ACT = `DDC_CMD_ACTIVATE;
  reg clk = 1'b0;
  reg rst, lm, um, otf, fc, w;
  wire lk, ke, cv, cr, ap, c4, lp, up;
  wire [3:0] e, cc;
  wire [2:0] bs, cb;
  wire [12:0] ad, ca;
  wire [1:0] ps;
  wire [7:0] bo;
  wire [103:0] rows;
  reg [7:0] om, o;
  reg [12:0] a;
  reg [2:0] b;
  integer n_errors, compares, n, i;
  always #2.5 clk = ~clk;
  ddc_ctrl_model ctl (.clk(clk), .link_clk(lk), .clk_en(ke), .enc(e),
    .bank(bs), .addr(ad));
  ddc_decoder dut (.clk(clk), .rst(rst), .link_clk(lk), .clk_en(ke),
    .chip_select_n(e[3]), .row_strobe_n(e[2]), .col_strobe_n(e[1]),
    .write_strobe_n(e[0]), .bank_select_bits(bs), .addr(ad),
    .lower_byte_mask(lm), .upper_byte_mask(um), .otf_chop_enable(otf),
    .fixed_chop(fc), .cmd_valid(cv), .cmd_code(cc), .cmd_bank(cb),
    .cmd_addr(ca), .cmd_auto_precharge(ap), .chopped_burst_of_four(c4),
    .burst_of_eight(), .cmd_refused(cr), .bank_open(bo),
    .open_rows(rows), .power_state(ps), .lower_pass(lp), .upper_pass(up));
  function [1:0] pwr(input [3:0] x);
    case (x)
      `DDC_CMD_SELF_REF_ENTRY: pwr = `DDC_PWR_SELF_REF;
      `DDC_CMD_PD_ENTRY: pwr = `DDC_PWR_DOWN;
      default: pwr = `DDC_PWR_ON;
    endcase
  endfunction
  function [7:0] nxt(input [7:0] m, input [3:0] x, input [2:0] q, input p);
    case (x)
      ACT: nxt = m | 8'h1 << q;
      `DDC_CMD_PRECHARGE: nxt = m & ~(8'h1 << q);
      `DDC_CMD_PRECHARGE_ALL: nxt = 8'h00;
      `DDC_CMD_READ, `DDC_CMD_WRITE: nxt = p ? m & ~(8'h1 << q) : m;
      default: nxt = m;
    endcase
  endfunction
  task stop_test;
    begin
      if (n_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [15:0] g, input [15:0] x);
    begin
      compares = compares + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task go(input [3:0] c, input [2:0] q, input [12:0] d, input k,
    input [3:0] x);
    begin
      fork
        ctl.send(c, q, d, k);
        begin
          for (n = 0; n < 20 && cv !== 1'b1 && cr !== 1'b1; n = n + 1)
            @(posedge clk) #1;
          if (n == 20) begin
            n_errors = n_errors + 1;
            stop_test;
          end
          chk(cr ? ILL : cc, x);
        end
      join
      if (x != ILL) om = nxt(om, x, q, d[10]);
      if (x != ILL) chk({cb, ca}, {q, d});
      if (x >= `DDC_CMD_SELF_REF_ENTRY && x <= `DDC_CMD_PD_EXIT)
        chk(ps, pwr(x));
      chk(bo, om);
      if (x == ACT) chk(rows[q*13 +: 13], d);
      if (x == `DDC_CMD_READ || x == `DDC_CMD_WRITE) begin
        chk(c4, otf ? !d[12] : fc);
        chk(ap, d[10]);
      end
    end
  endtask
  initial begin
    rst = 1'b1;
    {lm, um, otf, fc} = 4'h2;
    om = 8'h00;
    n_errors = 0;
    compares = 0;
    n = $urandom(32'h9e576cc8);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    go(4'h7, 0, 0, 1, `DDC_CMD_PD_EXIT);
    go(4'hf, 0, 0, 1, `DDC_CMD_DESELECT);
    go(4'h7, 0, 0, 1, `DDC_CMD_NOP);
    go(4'h0, 1, 0, 1, `DDC_CMD_MODE_LOAD);
    go(4'h1, 0, 0, 1, `DDC_CMD_REFRESH);
    go(4'h6, 0, 13'h400, 1, `DDC_CMD_CAL_LONG);
    go(4'h6, 0, 0, 1, `DDC_CMD_CAL_SHORT);
    go(4'h1, 0, 0, 0, `DDC_CMD_SELF_REF_ENTRY);
    go(4'h7, 0, 0, 1, `DDC_CMD_SELF_REF_EXIT);
    go(4'h7, 0, 0, 0, `DDC_CMD_PD_ENTRY);
    go(4'h0, 2, 13'h155, 0, `DDC_CMD_DESELECT);
    go(4'h7, 0, 0, 1, `DDC_CMD_PD_EXIT);
    go(4'h3, 0, 0, 0, ILL);
    go(4'h7, 0, 0, 1, `DDC_CMD_PD_EXIT);
    go(4'h2, 3, 0, 1, `DDC_CMD_PRECHARGE);
    for (i = 0; i < 8; i = i + 1) go(4'h3, i[2:0], i * 977, 1, ACT);
    go(4'h0, 0, 0, 1, ILL);
    go(4'h3, 5, 0, 1, ILL);
    for (i = 0; i < 80; i = i + 1) begin
      @(posedge clk);
      {b, a, w} = $urandom;
      o = om;
      {lm, um, otf, fc} <= $urandom;
      case ($urandom % 5)
        0, 1: go(4'h3, b, a, 1, om[b] ? ILL : ACT);
        2: go(4'h2, b, a, 1, a[10] ? 4'h4 : 4'h3);
        default: go({3'h2, w}, b, a, 1, om[b] ? 4'h5 + w : ILL);
      endcase
      if (o == om) chk({lp, up}, {2{|om}} & ~{lm, um});
    end
    stop_test;
  end
endmodule // test_dram_command_decoder
